// ==== mcp_parser.sv ====
// Section parser end: input FIFO, header and entry walk, CRC check, map banks.
`include "mcp_defs.svh"

module mcp_fifo #(
  parameter int W = 9,
  parameter int D = 16
) (
  input wire logic clk_sys_i,
  input wire logic rstn_i,
  // Filling side.
  input wire logic in_valid_i,
  input wire logic [W-1:0] in_data_i,
  output logic in_ready_o,
  // Draining side.
  output logic out_valid_o,
  output logic [W-1:0] out_data_o,
  input wire logic out_ready_i
);
  localparam int AW = $clog2(D);
  logic [W-1:0] mem_q [D];
  logic [AW-1:0] wr_q;
  logic [AW-1:0] rd_q;
  logic [AW:0] cnt_q;
  logic [AW:0] cnt_d;
  logic push;
  logic pop;

  assign push = in_valid_i & in_ready_o;
  assign pop = out_valid_o & out_ready_i;
  assign out_valid_o = (cnt_q != '0);
  assign out_data_o = mem_q[rd_q];

  // Occupancy after this cycle's push and pop.
  always_comb
  begin
    cnt_d = cnt_q;
    if (push && !pop)
      cnt_d = cnt_q + 1'b1;
    else if (pop && !push)
      cnt_d = cnt_q - 1'b1;
  end

  // Pointers, count and a registered ready so the link sees a flop.
  always_ff @(posedge clk_sys_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      wr_q <= '0;
      rd_q <= '0;
      cnt_q <= '0;
      in_ready_o <= 1'b0;
    end
    else
    begin
      if (push)
        wr_q <= wr_q + 1'b1;
      if (pop)
        rd_q <= rd_q + 1'b1;
      cnt_q <= cnt_d;
      in_ready_o <= (cnt_d < (AW+1)'(D));
    end
  end

  // Storage needs no reset; only words below the count are ever read.
  always_ff @(posedge clk_sys_i)
  begin
    if (push)
      mem_q[wr_q] <= in_data_i;
  end
endmodule

module mcp_parser (
  input wire logic clk_sys_i,
  input wire logic rstn_i,
  // Link from the demultiplexer.
  mcp_if.snk link,
  // Flow control from the filtering logic.
  input wire logic hold_i,
  // Applied map read port.
  input wire logic [3:0] rd_idx_i,
  output mcp_pkg::mcp_entry_t rd_entry_o,
  // Map status.
  output logic map_valid_o,
  output logic [4:0] map_version_o,
  output logic [4:0] map_count_o,
  output logic applied_o,
  output logic next_valid_o,
  output logic [4:0] next_version_o,
  // Error report.
  output logic err_o,
  output logic [2:0] err_code_o
);
  import mcp_pkg::*;

  logic f_valid;
  logic [8:0] f_data;
  logic pop;
  logic [7:0] b;
  logic s;
  mcp_state_t state_q;
  logic [2:0] hpos_q;
  logic [4:0] epos_q;
  logic [11:0] rem_q;
  logic [11:0] rem_n;
  logic [31:0] crc_q;
  logic [31:0] crc_d;
  logic syn_q;
  logic [4:0] ver_q;
  logic cn_q;
  logic [7:0] sec_q;
  logic [4:0] cnt_q;
  logic bank_q;
  mcp_entry_t ent_q;
  mcp_entry_t ent_d;
  mcp_entry_t map_q [2*`MCP_MAP_DEPTH];
  logic ent_end;

  // Byte-wise MSB-first CRC-32 with the standard section polynomial.
  function automatic logic [31:0] crc_byte(input logic [31:0] c, input logic [7:0] d);
    logic [31:0] r;
    r = c;
    for (int i = 7; i >= 0; i--)
      r = (r[31] ^ d[i]) ? ((r << 1) ^ `MCP_CRC_POLY) : (r << 1);
    return r;
  endfunction

  mcp_fifo #(.W(9), .D(`MCP_FIFO_DEPTH)) u_fifo (
    .clk_sys_i(clk_sys_i),
    .rstn_i(rstn_i),
    .in_valid_i(link.valid),
    .in_data_i({link.sos, link.data}),
    .in_ready_o(link.ready),
    .out_valid_o(f_valid),
    .out_data_o(f_data),
    .out_ready_i(!hold_i)
  );

  // The hold input stalls draining so the FIFO fills and stops the link.
  assign pop = f_valid & !hold_i;
  assign b = f_data[7:0];
  assign s = f_data[8];
  assign rem_n = rem_q - 12'h001;
  assign crc_d = crc_byte(s ? `MCP_CRC_INIT : crc_q, b);
  assign ent_end = ent_d.v6 ? (epos_q == `MCP_ENT_V6_END) : (epos_q == `MCP_ENT_V4_END);

  // Entry under assembly including the byte now being consumed.
  always_comb
  begin
    ent_d = ent_q;
    if (epos_q == 5'h00)
    begin
      ent_d = '0;
      ent_d.v6 = b[7];
      ent_d.pid[12:8] = b[4:0];
    end
    else if (epos_q == 5'h01)
      ent_d.pid[7:0] = b;
    else if (epos_q < 5'h06)
      ent_d.ipv4[8*(5-epos_q) +: 8] = b;
    else
      ent_d.ipv6[8*(17-epos_q) +: 8] = b;
  end

  // Section walk: header, entries, CRC, with restart on any start byte.
  always_ff @(posedge clk_sys_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      state_q <= MCP_S_IDLE;
      hpos_q <= 3'h0;
      epos_q <= 5'h00;
      rem_q <= 12'h000;
      crc_q <= `MCP_CRC_INIT;
      syn_q <= 1'b0;
      ver_q <= 5'h00;
      cn_q <= 1'b0;
      sec_q <= 8'h00;
      cnt_q <= 5'h00;
      ent_q <= '0;
      err_o <= 1'b0;
      err_code_o <= `MCP_ERR_NONE;
    end
    else
    begin
      err_o <= 1'b0;
      if (pop)
      begin
        crc_q <= crc_d;
        if (s)
        begin
          hpos_q <= 3'h1;
          if ((state_q != MCP_S_IDLE) && (state_q != MCP_S_DROP))
          begin
            err_o <= 1'b1;
            err_code_o <= `MCP_ERR_TRUNC;
          end
          if (b == `MCP_TABLE_ID)
            state_q <= MCP_S_HDR;
          else
          begin
            state_q <= MCP_S_DROP;
            err_o <= 1'b1;
            err_code_o <= `MCP_ERR_TID;
          end
        end
        else
        begin
          if (state_q != MCP_S_HDR || hpos_q > 3'h2)
            rem_q <= rem_n;
          unique case (state_q)
            MCP_S_IDLE, MCP_S_DROP:
            begin
              state_q <= state_q;
            end
            MCP_S_HDR:
            begin
              hpos_q <= hpos_q + 3'h1;
              // Fields in fixed order; private bit and extension are ignored.
              unique case (hpos_q)
                3'h1:
                begin
                  syn_q <= b[7];
                  rem_q <= {b[3:0], 8'h00};
                end
                3'h2:
                begin
                  rem_q <= {rem_q[11:8], b};
                  if ({rem_q[11:8], b} > `MCP_LEN_MAX)
                  begin
                    state_q <= MCP_S_DROP;
                    err_o <= 1'b1;
                    err_code_o <= `MCP_ERR_LEN;
                  end
                  else if (!syn_q)
                    state_q <= ({rem_q[11:8], b} == 12'h000) ? MCP_S_IDLE : MCP_S_RAW;
                  else if ({rem_q[11:8], b} < `MCP_LEN_MIN)
                  begin
                    state_q <= MCP_S_DROP;
                    err_o <= 1'b1;
                    err_code_o <= `MCP_ERR_LEN;
                  end
                end
                3'h3, 3'h4:
                begin
                  hpos_q <= hpos_q + 3'h1;
                end
                3'h5:
                begin
                  ver_q <= b[5:1];
                  cn_q <= b[0];
                end
                3'h6:
                begin
                  sec_q <= b;
                end
                default:
                begin
                  epos_q <= 5'h00;
                  cnt_q <= 5'h00;
                  if (sec_q > b)
                  begin
                    state_q <= MCP_S_DROP;
                    err_o <= 1'b1;
                    err_code_o <= `MCP_ERR_SECNUM;
                  end
                  else
                    state_q <= (rem_n == `MCP_CRC_LEN) ? MCP_S_CRC : MCP_S_ENT;
                end
              endcase
            end
            MCP_S_ENT:
            begin
              ent_q <= ent_d;
              epos_q <= ent_end ? 5'h00 : epos_q + 5'h01;
              if (ent_end)
                cnt_q <= cnt_q + 5'h01;
              if (ent_end && cnt_q == 5'(`MCP_MAP_DEPTH))
              begin
                state_q <= MCP_S_DROP;
                err_o <= 1'b1;
                err_code_o <= `MCP_ERR_FULL;
              end
              else if (rem_n == `MCP_CRC_LEN)
              begin
                state_q <= ent_end ? MCP_S_CRC : MCP_S_DROP;
                if (!ent_end)
                begin
                  err_o <= 1'b1;
                  err_code_o <= `MCP_ERR_TRUNC;
                end
              end
            end
            MCP_S_CRC:
            begin
              if (rem_n == 12'h000)
              begin
                state_q <= MCP_S_IDLE;
                if (crc_d != 32'h0000_0000)
                begin
                  err_o <= 1'b1;
                  err_code_o <= `MCP_ERR_CRC;
                end
              end
            end
            MCP_S_RAW:
            begin
              if (rem_n == 12'h000)
                state_q <= MCP_S_IDLE;
            end
            default:
            begin
              state_q <= MCP_S_IDLE;
            end
          endcase
        end
      end
    end
  end

  // Entries land in the pending bank; the applied bank is never touched.
  always_ff @(posedge clk_sys_i)
  begin
    if (pop && !s && state_q == MCP_S_ENT && ent_end && cnt_q < 5'(`MCP_MAP_DEPTH))
      map_q[{!bank_q, cnt_q[3:0]}] <= ent_d;
  end

  // Commit on the last CRC byte only, so a map never changes mid-section.
  always_ff @(posedge clk_sys_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      bank_q <= 1'b0;
      map_valid_o <= 1'b0;
      map_version_o <= 5'h00;
      map_count_o <= 5'h00;
      applied_o <= 1'b0;
      next_valid_o <= 1'b0;
      next_version_o <= 5'h00;
    end
    else
    begin
      applied_o <= 1'b0;
      if (pop && !s && state_q == MCP_S_CRC && rem_n == 12'h000 && crc_d == 32'h0)
      begin
        if (!cn_q)
        begin
          next_valid_o <= 1'b1;
          next_version_o <= ver_q;
        end
        else if (!map_valid_o || ver_q != map_version_o)
        begin
          bank_q <= !bank_q;
          map_valid_o <= 1'b1;
          map_version_o <= ver_q;
          map_count_o <= cnt_q;
          applied_o <= 1'b1;
          if (next_version_o == ver_q)
            next_valid_o <= 1'b0;
        end
      end
    end
  end

  // Registered read of the applied bank.
  always_ff @(posedge clk_sys_i or negedge rstn_i)
  begin
    if (!rstn_i)
      rd_entry_o <= '0;
    else
      rd_entry_o <= map_q[{bank_q, rd_idx_i}];
  end
endmodule

// ==== mcp_defs.svh ====
// Constants shared by both ends of the multicast map section link.
`ifndef MCP_DEFS_SVH
`define MCP_DEFS_SVH
`define MCP_TABLE_ID 8'hc0
`define MCP_LEN_MAX 12'hffd
`define MCP_LEN_MIN 12'h009
`define MCP_CRC_LEN 12'h004
`define MCP_CRC_POLY 32'h04c11db7
`define MCP_CRC_INIT 32'hffffffff
`define MCP_HDR_LAST 3'h7
`define MCP_ENT_V4_END 5'h05
`define MCP_ENT_V6_END 5'h11
`define MCP_FIFO_DEPTH 16
`define MCP_MAP_DEPTH 16
`define MCP_ERR_NONE 3'h0
`define MCP_ERR_TID 3'h1
`define MCP_ERR_LEN 3'h2
`define MCP_ERR_CRC 3'h3
`define MCP_ERR_TRUNC 3'h4
`define MCP_ERR_SECNUM 3'h5
`define MCP_ERR_FULL 3'h6
`endif

// ==== mcp_pkg.sv ====
// Types shared by both ends of the multicast map section link.
package mcp_pkg;
  typedef enum logic [2:0] {
    MCP_S_IDLE = 3'b000,
    MCP_S_HDR  = 3'b001,
    MCP_S_ENT  = 3'b010,
    MCP_S_CRC  = 3'b011,
    MCP_S_RAW  = 3'b100,
    MCP_S_DROP = 3'b101
  } mcp_state_t;

  typedef struct packed {
    logic        v6;
    logic [12:0] pid;
    logic [31:0] ipv4;
    logic [95:0] ipv6;
  } mcp_entry_t;
endpackage

// ==== mcp_if.sv ====
// Byte stream carrying multicast map sections from producer to parser.
interface mcp_if;
  logic       valid;
  logic       ready;
  logic [7:0] data;
  logic       sos;

  // Producer end drives bytes, parser end answers with ready.
  modport src (output valid, output data, output sos, input ready);
  modport snk (input valid, input data, input sos, output ready);
endinterface

// ==== mcp_producer.sv ====
// Producer end: registers section bytes onto the link and checks the header.
`include "mcp_defs.svh"

module mcp_producer (
  input wire logic clk_sys_i,
  input wire logic rstn_i,
  // Section bytes from the table source.
  input wire logic src_valid_i,
  input wire logic [7:0] src_data_i,
  input wire logic src_sos_i,
  output logic src_ready_o,
  // Link toward the parser.
  mcp_if.src link,
  // Header checks and activity.
  output logic len_err_o,
  output logic rsv_err_o,
  output logic [15:0] sections_o
);
  import mcp_pkg::*;

  logic vld_q;
  logic [7:0] dat_q;
  logic sos_q;
  logic [1:0] pos_q;
  logic [3:0] len_hi_q;
  logic take;
  logic send;

  // One holding stage; half rate is traded for a flop-driven ready.
  assign take = src_valid_i & src_ready_o;
  assign send = vld_q & link.ready;
  assign link.valid = vld_q;
  assign link.data = dat_q;
  assign link.sos = sos_q;

  // Holding stage and ready.
  always_ff @(posedge clk_sys_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      vld_q <= 1'b0;
      dat_q <= 8'h00;
      sos_q <= 1'b0;
      src_ready_o <= 1'b0;
    end
    else
    begin
      if (take)
      begin
        vld_q <= 1'b1;
        dat_q <= src_data_i;
        sos_q <= src_sos_i;
        src_ready_o <= 1'b0;
      end
      else if (send)
      begin
        vld_q <= 1'b0;
        src_ready_o <= 1'b1;
      end
      else
        src_ready_o <= !vld_q;
    end
  end

  // Header watch on bytes leaving the link: reserved bits and length cap.
  always_ff @(posedge clk_sys_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      pos_q <= 2'h3;
      len_hi_q <= 4'h0;
      len_err_o <= 1'b0;
      rsv_err_o <= 1'b0;
      sections_o <= 16'h0000;
    end
    else
    begin
      len_err_o <= 1'b0;
      rsv_err_o <= 1'b0;
      if (send)
      begin
        if (sos_q)
        begin
          pos_q <= 2'h1;
          sections_o <= sections_o + 16'h0001;
        end
        else if (pos_q == 2'h1)
        begin
          pos_q <= 2'h2;
          len_hi_q <= dat_q[3:0];
          rsv_err_o <= (dat_q[5:4] != 2'b11);
        end
        else if (pos_q == 2'h2)
        begin
          pos_q <= 2'h3;
          len_err_o <= ({len_hi_q, dat_q} > `MCP_LEN_MAX);
        end
      end
    end
  end
endmodule

// ==== mcp_link_properties.sv ====
// Checker for the section byte link between producer and parser.
module mcp_link_properties (
  // Clock and reset.
  input wire logic clk_sys_i,
  input wire logic rstn_i,
  // Link signals.
  input wire logic valid,
  input wire logic ready,
  input wire logic [7:0] data,
  input wire logic sos
);
  logic [2:0] edge_q;
  logic [11:0] pos_q;
  logic [11:0] len_q;
  logic [7:0] sec_q;
  logic syn_q;
  logic take;
  logic [11:0] idx;

  // A start byte restarts the byte index.
  assign take = valid && ready;
  assign idx = sos ? 12'h000 : pos_q;

  // Edges since reset; it saturates so a long run never wraps it.
  always_ff @(posedge clk_sys_i or negedge rstn_i)
  begin
    if (!rstn_i) edge_q <= 3'h0;
    else if (edge_q != 3'h7) edge_q <= edge_q + 3'h1;
  end

  // Length starts out of range, so the first section is not judged on stale data.
  always_ff @(posedge clk_sys_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      pos_q <= 12'h000;
      len_q <= 12'hfff;
      sec_q <= 8'h00;
      syn_q <= 1'b0;
    end
    else if (take)
    begin
      pos_q <= idx + 12'h001;
      // Raw sections carry private bytes, so the long-form checks follow the syntax bit.
      if (idx == 12'h001) syn_q <= data[7];
      if (idx == 12'h001) len_q[11:8] <= data[3:0];
      if (idx == 12'h002) len_q[7:0] <= data;
      if (idx == 12'h006) sec_q <= data;
    end
  end

  default clocking cb @(posedge clk_sys_i);
  endclocking
  default disable iff (!rstn_i);

  quiet_after_reset_a: assert property (edge_q < 3'h2 |-> !valid)
    else $error("byte offered too soon after reset");
  ready_after_reset_a: assert property (edge_q == 3'h1 |-> ready)
    else $error("parser not ready after reset");
  byte_held_a: assert property (
    valid && !ready |=> valid && $stable(data) && $stable(sos))
    else $error("byte changed before it was taken");
  gap_after_take_a: assert property (take |=> !valid)
    else $error("no idle cycle after a taken byte");
  section_span_a: assert property (
    take && sos && len_q <= 12'hffd |-> {1'b0, pos_q} == {1'b0, len_q} + 13'h0003)
    else $error("section size differs from its length field");
  head_reserved_a: assert property (take && idx == 12'h001 |-> data[5:4] == 2'b11)
    else $error("header reserved bits not set");
  vers_reserved_a: assert property (
    take && syn_q && idx == 12'h005 |-> data[7:6] == 2'b11)
    else $error("version reserved bits not set");
  last_section_a: assert property (
    take && syn_q && idx == 12'h007 |-> data >= sec_q)
    else $error("last section number below section number");

  stall_c: cover property (valid && !ready);
  start_c: cover property (take && sos);
  span_c: cover property (take && sos && len_q <= 12'hffd);
endmodule

// ==== tb.sv ====
// Self-checking bench for the producer, link and parser pair.
module tb;
  timeunit 1ns;
  timeprecision 100ps;
  import mcp_pkg::*;
  logic clk_sys_i = 1'b0;
  logic rstn_i = 1'b0;
  logic src_valid_i = 1'b0;
  logic src_sos_i = 1'b0;
  logic [7:0] src_data_i = 8'h00;
  logic hold_i = 1'b0;
  logic [3:0] rd_idx_i = 4'h0;
  logic src_ready_o, len_err_o, rsv_err_o, map_valid_o, applied_o, next_valid_o, err_o;
  logic [15:0] sections_o;
  logic [4:0] map_version_o, map_count_o, next_version_o;
  logic [2:0] err_code_o;
  mcp_entry_t rd_entry_o, e0, e1, e2;
  mcp_entry_t ents[$];
  logic [7:0] sec[$];
  int errors = 0, check_count = 0, applies = 0, errs = 0, len_errs = 0, rsv_errs = 0;

  mcp_if lnk ();
  mcp_producer i_mcp_producer (.clk_sys_i(clk_sys_i), .rstn_i(rstn_i),
    .src_valid_i(src_valid_i), .src_data_i(src_data_i), .src_sos_i(src_sos_i),
    .src_ready_o(src_ready_o), .link(lnk), .len_err_o(len_err_o),
    .rsv_err_o(rsv_err_o), .sections_o(sections_o));
  mcp_parser i_mcp_parser (.clk_sys_i(clk_sys_i), .rstn_i(rstn_i), .link(lnk),
    .hold_i(hold_i), .rd_idx_i(rd_idx_i), .rd_entry_o(rd_entry_o),
    .map_valid_o(map_valid_o), .map_version_o(map_version_o), .map_count_o(map_count_o),
    .applied_o(applied_o), .next_valid_o(next_valid_o), .next_version_o(next_version_o),
    .err_o(err_o), .err_code_o(err_code_o));
  mcp_link_properties i_mcp_link_properties (.clk_sys_i(clk_sys_i), .rstn_i(rstn_i),
    .valid(lnk.valid), .ready(lnk.ready), .data(lnk.data), .sos(lnk.sos));

  // A 40 MHz clock.
  always #12.5 clk_sys_i = ~clk_sys_i;

  // Pulses are one cycle wide, so they are tallied at every edge.
  always @(posedge clk_sys_i)
  begin
    if (applied_o === 1'b1) applies++;
    if (err_o === 1'b1) errs++;
    if (len_err_o === 1'b1) len_errs++;
    if (rsv_err_o === 1'b1) rsv_errs++;
  end

  // Prints the tallies and the verdict.
  task automatic close_out();
    $display("Mismatches %0d, comparisons %0d", errors, check_count);
    if (errors == 0 && check_count > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  // Compares one value and counts it.
  task automatic check(input logic [141:0] seen, input logic [141:0] exp);
    check_count++;
    if (seen !== exp)
    begin
      errors++;
      $display("FAIL at %0t: saw %0h, expected %0h", $time, seen, exp);
    end
  endtask

  // Offers each byte until taken; a stuck producer ends the run.
  task automatic send(input int n);
    int t;
    @(posedge clk_sys_i);
    for (int i = 0; i < n; i++)
    begin
      src_valid_i <= 1'b1;
      src_data_i <= sec[i];
      src_sos_i <= (i == 0);
      t = 0;
      do
      begin
        @(posedge clk_sys_i);
        t++;
      end
      while (src_ready_o !== 1'b1 && t < 400);
      if (t >= 400)
      begin
        errors++;
        close_out();
      end
    end
    src_valid_i <= 1'b0;
    src_sos_i <= 1'b0;
  endtask

  // Lets the FIFO run dry, then steps off the edge so tallies are settled.
  task automatic settle();
    repeat (30) @(posedge clk_sys_i);
    @(negedge clk_sys_i);
  endtask

  // Builds a section from the entry list with a good or spoilt check word.
  task automatic mk(input logic [7:0] tid, input logic syn, input logic prv,
    input logic cn, input logic [4:0] ver, input logic bad);
    logic [11:0] len;
    logic [31:0] crc;
    logic [63:0] hdr;
    len = 12'h009;
    foreach (ents[i]) len = len + (ents[i].v6 ? 12'h012 : 12'h006);
    hdr = {tid, syn, prv, 2'b11, len, ver, 3'h5, ver, 3'h2, 2'b11, ver, cn, 16'h0000};
    sec.delete();
    for (int k = 7; k >= 0; k--) sec.push_back(hdr[8*k+:8]);
    foreach (ents[i])
    begin
      sec.push_back({ents[i].v6, 2'b11, ents[i].pid[12:8]});
      sec.push_back(ents[i].pid[7:0]);
      for (int k = 3; k >= 0; k--) sec.push_back(ents[i].ipv4[8*k+:8]);
      for (int k = 11; k >= 0 && ents[i].v6; k--) sec.push_back(ents[i].ipv6[8*k+:8]);
    end
    crc = 32'hffffffff;
    foreach (sec[i])
      for (int b = 7; b >= 0; b--)
        crc = {crc[30:0], 1'b0} ^ ((crc[31] ^ sec[i][b]) ? 32'h04c11db7 : 32'h0);
    crc[0] = crc[0] ^ bad;
    for (int k = 3; k >= 0; k--) sec.push_back(crc[8*k+:8]);
  endtask

  // Builds, sends and lets one whole section drain.
  task automatic run(input logic [7:0] tid, input logic syn, input logic prv,
    input logic cn, input logic [4:0] ver, input logic bad);
    mk(tid, syn, prv, cn, ver, bad);
    send(sec.size());
    settle();
  endtask

  // Reads one applied entry through the registered read port.
  task automatic rd_check(input logic [3:0] i, input mcp_entry_t e);
    @(posedge clk_sys_i);
    rd_idx_i <= i;
    repeat (2) @(posedge clk_sys_i);
    @(negedge clk_sys_i);
    check({rd_entry_o.v6, rd_entry_o.pid, rd_entry_o.ipv4}, {e.v6, e.pid, e.ipv4});
    if (e.v6) check(rd_entry_o.ipv6, e.ipv6);
  endtask

  initial
  begin
    e0 = {1'b0, 13'h0123, 32'he0010203, 96'h0};
    e1 = {1'b1, 13'h1ffe, 32'hc0a80001, 96'hff02_0000_1111_2222_3333_4444};
    e2 = {1'b0, 13'h0040, 32'hef00fe01, 96'h0};
    repeat (12) @(posedge clk_sys_i);
    rstn_i <= 1'b1;
    repeat (2) @(posedge clk_sys_i);
    check(map_valid_o, 1'b0);
    // The parser is held so the FIFO fills and refuses mid-section.
    ents = '{e0, e1};
    mk(8'hc0, 1'b1, 1'b0, 1'b1, 5'h01, 1'b0);
    fork
      send(sec.size());
      begin
        hold_i <= 1'b1;
        repeat (90) @(posedge clk_sys_i);
        @(negedge clk_sys_i);
        check(lnk.ready, 1'b0);
        check(applies, 0);
        @(posedge clk_sys_i);
        hold_i <= 1'b0;
      end
    join
    settle();
    check(applies, 1);
    check({map_valid_o, map_version_o}, {1'b1, 5'h01});
    check(map_count_o, 5'h02);
    rd_check(4'h0, e0);
    rd_check(4'h1, e1);
    // A next version is held and not applied.
    run(8'hc0, 1'b1, 1'b0, 1'b0, 5'h02, 1'b0);
    check({next_valid_o, next_version_o, map_version_o}, {1'b1, 5'h02, 5'h01});
    // A spoilt check word drops the section and keeps the old map.
    run(8'hc0, 1'b1, 1'b0, 1'b1, 5'h03, 1'b1);
    check({errs, err_code_o}, {32'h1, 3'h3});
    check({applies, map_version_o}, {32'h1, 5'h01});
    // A foreign identifier is ignored with an error.
    run(8'hc1, 1'b1, 1'b0, 1'b1, 5'h03, 1'b0);
    check({errs, err_code_o, applies}, {32'h2, 3'h1, 32'h1});
    // Raw private data is skipped silently.
    run(8'hc0, 1'b0, 1'b0, 1'b1, 5'h04, 1'b0);
    check({errs, applies}, {32'h2, 32'h1});
    // An over-length header is cut short after the length field.
    mk(8'hc0, 1'b1, 1'b0, 1'b1, 5'h05, 1'b0);
    sec[1] = 8'hbf;
    sec[2] = 8'hfe;
    send(3);
    settle();
    check({errs, err_code_o, len_errs}, {32'h3, 3'h2, 32'h1});
    // Private flag set and a new extension value: applied as usual.
    ents = '{e2};
    run(8'hc0, 1'b1, 1'b1, 1'b1, 5'h02, 1'b0);
    check({applies, map_count_o}, {32'h2, 5'h01});
    check({map_version_o, next_valid_o}, {5'h02, 1'b0});
    rd_check(4'h0, e2);
    // The same current version again changes nothing.
    run(8'hc0, 1'b1, 1'b0, 1'b1, 5'h02, 1'b0);
    check(applies, 2);
    check({sections_o, rsv_errs}, {16'h0008, 32'h0});
    // Seventeen entries overflow a map bank, so the section is dropped.
    ents.delete();
    repeat (17) ents.push_back(e0);
    run(8'hc0, 1'b1, 1'b0, 1'b1, 5'h03, 1'b0);
    check({errs, err_code_o, applies, map_count_o}, {32'h4, 3'h6, 32'h2, 5'h01});
    close_out();
  end
endmodule
